// ===== rtl/rcr_pkg.sv
/*
 reset cause and remap package: register offsets, field positions, reset
 values and the bus carrier structs.
 assumes an APB slave with 32-bit data and word-aligned registers.
*/
// Functional notes
// - four reset causes are accepted: external pin, power-on, watchdog expiry and software force.
// - a power-on reset sets bit 0 of reset_cause_status.
// - a watchdog timeout reset sets bit 1 of reset_cause_status.
// - writing 1 to bit 2 of reset_cause_status forces a software reset and records it in bit 2.
// - each cause bit stays set until a 1 is written to the same bit of reset_cause_clear or an external pin reset clears the register.
// - an all-zero reset_cause_status means the last reset came from the external pin.
// - a clear that leaves any set cause bit uncleared raises a reset event.
// - setting bit 0 of low_memory_map_select mirrors SRAM at address zero.
// - an external pin, watchdog or software reset clears the remap bit so Flash is mirrored at address zero again.
package rcr_pkg;
   localparam logic [11:0] RCR_OFS_REMAP  = 12'h000;
   localparam logic [11:0] RCR_OFS_STATUS = 12'h004;
   localparam logic [11:0] RCR_OFS_CLEAR  = 12'h008;
   localparam int          RCR_BIT_POR    = 0;
   localparam int          RCR_BIT_WDT    = 1;
   localparam int          RCR_BIT_SWR    = 2;
   localparam int          RCR_BIT_REMAP  = 0;
   localparam logic [7:0]  RCR_CAUSE_MASK = 8'h07;
   localparam logic [7:0]  RCR_CAUSE_RST  = 8'h00;
   localparam logic        RCR_REMAP_RST  = 1'b0;
   localparam logic [3:0]  RCR_PULSE_LEN  = 4'h8;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } rcr_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } rcr_apb_rsp_t;
endpackage : rcr_pkg

// ===== rtl/rcr_core.sv
/*
 reset cause recorder and low memory remap select with an APB slave.
 assumes reset sources arrive asynchronously and are synchronised here;
 sys_rst_req feeds the chip reset controller, which later resets
 this block through ext/por/wdt inputs (not arst_n, which is por-only).
*/
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module rcr_core (
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   input  wire rcr_pkg::rcr_apb_req_t apb_req,
   output rcr_pkg::rcr_apb_rsp_t      apb_rsp,
   input  wire logic                  por_evt,
   input  wire logic                  wdt_evt,
   input  wire logic                  ext_rst_evt,
   output logic                       sys_rst_req,
   output logic                       sram_at_zero
);
   import rcr_pkg::*;

   typedef struct packed {
      logic [1:0]   por_s;
      logic [1:0]   wdt_s;
      logic [1:0]   ext_s;
      logic         wdt_d;
      logic         ext_d;
      logic         por_seen;
      logic [7:0]   cause;
      logic         remap;
      logic [3:0]   pulse_cnt;
      logic         rst_req;
      rcr_apb_rsp_t rsp;
   } rcr_state_t;

   rcr_state_t st_r;
   rcr_state_t st_nxt;

   ////////////////////////////////////////////////////////////////////////
   logic        wr_acc;
   logic        rd_acc;
   logic        wdt_rise;
   logic        ext_rise;
   logic        sw_force;
   logic        clr_hit;
   logic [7:0]  clr_bits;
   logic [7:0]  set_bits;
   logic        any_reset;

   always_comb begin
      wr_acc   = apb_req.psel && apb_req.penable && apb_req.pwrite;
      rd_acc   = apb_req.psel && apb_req.penable && !apb_req.pwrite;
      // only the second stage is read; first stage feeds nothing else
      wdt_rise = st_r.wdt_s[1] && !st_r.wdt_d;
      ext_rise = st_r.ext_s[1] && !st_r.ext_d;
      sw_force = wr_acc && apb_req.paddr == RCR_OFS_STATUS
                 && apb_req.pwdata[RCR_BIT_SWR];
      clr_hit  = wr_acc && apb_req.paddr == RCR_OFS_CLEAR;
      clr_bits = clr_hit ? apb_req.pwdata[7:0] & RCR_CAUSE_MASK
                         : 8'h00;
      set_bits = 8'h00;
      set_bits[RCR_BIT_POR] = st_r.por_s[1] && !st_r.por_seen;
      set_bits[RCR_BIT_WDT] = wdt_rise;
      set_bits[RCR_BIT_SWR] = sw_force;
      // external reset leaves no mark so the register reads null
      any_reset = ext_rise || wdt_rise || sw_force;

      st_nxt = st_r;
      st_nxt.por_s    = {st_r.por_s[0], por_evt};
      st_nxt.wdt_s    = {st_r.wdt_s[0], wdt_evt};
      st_nxt.ext_s    = {st_r.ext_s[0], ext_rst_evt};
      st_nxt.wdt_d    = st_r.wdt_s[1];
      st_nxt.ext_d    = st_r.ext_s[1];
      if (st_r.por_s[1])
         st_nxt.por_seen = 1'b1;
      // set wins over clear in the same cycle
      st_nxt.cause = (st_r.cause & ~clr_bits) | set_bits;
      if (ext_rise)
         st_nxt.cause = set_bits;
      if (wr_acc && apb_req.paddr == RCR_OFS_REMAP)
         st_nxt.remap = apb_req.pwdata[RCR_BIT_REMAP];
      if (any_reset)
         st_nxt.remap = RCR_REMAP_RST;

      // partial clear of the set cause bits forces a reset
      if (any_reset || (clr_hit && ((st_r.cause & ~clr_bits) != 8'h00)))
         st_nxt.pulse_cnt = RCR_PULSE_LEN;
      else if (st_r.pulse_cnt != 4'h0)
         st_nxt.pulse_cnt = st_r.pulse_cnt - 4'h1;
      st_nxt.rst_req = st_nxt.pulse_cnt != 4'h0;

      st_nxt.rsp.pready  = apb_req.psel && !apb_req.penable;
      st_nxt.rsp.pslverr = 1'b0;
      st_nxt.rsp.prdata  = 32'h0000_0000;
      if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
         unique case (apb_req.paddr)
            RCR_OFS_REMAP:  st_nxt.rsp.prdata = {31'h0, st_r.remap};
            RCR_OFS_STATUS: st_nxt.rsp.prdata = {24'h0, st_r.cause};
            RCR_OFS_CLEAR:  st_nxt.rsp.prdata = 32'h0000_0000;
            default:        st_nxt.rsp.pslverr = 1'b1;
         endcase
      end
      if (apb_req.psel && !apb_req.penable && apb_req.pwrite
          && apb_req.paddr != RCR_OFS_REMAP
          && apb_req.paddr != RCR_OFS_STATUS
          && apb_req.paddr != RCR_OFS_CLEAR)
         st_nxt.rsp.pslverr = 1'b1;
      if (rd_acc)
         st_nxt.rsp.pready = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // arst_n is the power-on reset: everything, remap included, clears
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r       <= '0;
         st_r.cause <= RCR_CAUSE_RST;
         st_r.remap <= RCR_REMAP_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_comb begin
      apb_rsp      = st_r.rsp;
      sys_rst_req  = st_r.rst_req;
      sram_at_zero = st_r.remap;
   end

   ////////////////////////////////////////////////////////////////////////
   property p_swr_sets;
      @(posedge clk) disable iff (!arst_n)
      sw_force |=> st_r.cause[RCR_BIT_SWR];
   endproperty
   a_swr_sets: assert property (p_swr_sets)
      else $error("software force not recorded");

   property p_wdt_sets;
      @(posedge clk) disable iff (!arst_n)
      wdt_rise |=> st_r.cause[RCR_BIT_WDT] ##0 sys_rst_req;
   endproperty
   a_wdt_sets: assert property (p_wdt_sets)
      else $error("watchdog cause or reset missing");

   property p_sticky;
      @(posedge clk) disable iff (!arst_n)
      (st_r.cause[RCR_BIT_WDT] && !clr_bits[RCR_BIT_WDT] && !ext_rise)
      |=> st_r.cause[RCR_BIT_WDT];
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("cause bit lost without clear");

   property p_partial_clr;
      @(posedge clk) disable iff (!arst_n)
      (clr_hit && (st_r.cause & ~clr_bits) != 8'h00)
      |=> sys_rst_req [*8];
   endproperty
   a_partial_clr: assert property (p_partial_clr)
      else $error("partial clear gave no reset");

   property p_remap_rst;
      @(posedge clk) disable iff (!arst_n)
      any_reset |=> !sram_at_zero;
   endproperty
   a_remap_rst: assert property (p_remap_rst)
      else $error("remap not cleared on reset");

   property p_remap_wr;
      @(posedge clk) disable iff (!arst_n)
      (wr_acc && apb_req.paddr == RCR_OFS_REMAP && !any_reset)
      |=> sram_at_zero == $past(apb_req.pwdata[RCR_BIT_REMAP]);
   endproperty
   a_remap_wr: assert property (p_remap_wr)
      else $error("remap write not taken");

   property p_ext_null;
      @(posedge clk) disable iff (!arst_n)
      (ext_rise && set_bits == 8'h00) |=> st_r.cause == 8'h00;
   endproperty
   a_ext_null: assert property (p_ext_null)
      else $error("external reset left cause bits");

   property p_clr_rd;
      @(posedge clk) disable iff (!arst_n)
      (rd_acc && apb_req.paddr == RCR_OFS_CLEAR && apb_rsp.pready)
      |-> apb_rsp.prdata == 32'h0000_0000;
   endproperty
   a_clr_rd: assert property (p_clr_rd)
      else $error("clear register read nonzero");

   ////////////////////////////////////////////////////////////////////////
   // per-bit set and clear checks; set wins when both land together
   property p_por_sets;
      @(posedge clk) disable iff (!arst_n)
      (st_r.por_s[1] && !st_r.por_seen) |=> st_r.cause[RCR_BIT_POR];
   endproperty
   a_por_sets: assert property (p_por_sets)
      else $error("power-on cause not recorded");

   property p_swr_req;
      @(posedge clk) disable iff (!arst_n)
      sw_force |=> sys_rst_req;
   endproperty
   a_swr_req: assert property (p_swr_req)
      else $error("software force gave no reset request");

   property p_ext_req;
      @(posedge clk) disable iff (!arst_n)
      ext_rise |=> sys_rst_req && !sram_at_zero;
   endproperty
   a_ext_req: assert property (p_ext_req)
      else $error("external reset not acted on");

   property p_sticky_por;
      @(posedge clk) disable iff (!arst_n)
      (st_r.cause[RCR_BIT_POR] && !clr_bits[RCR_BIT_POR] && !ext_rise)
      |=> st_r.cause[RCR_BIT_POR];
   endproperty
   a_sticky_por: assert property (p_sticky_por)
      else $error("power-on cause lost without clear");

   property p_sticky_swr;
      @(posedge clk) disable iff (!arst_n)
      (st_r.cause[RCR_BIT_SWR] && !clr_bits[RCR_BIT_SWR] && !ext_rise)
      |=> st_r.cause[RCR_BIT_SWR];
   endproperty
   a_sticky_swr: assert property (p_sticky_swr)
      else $error("software cause lost without clear");

   property p_clr_por;
      @(posedge clk) disable iff (!arst_n)
      (clr_bits[RCR_BIT_POR] && !set_bits[RCR_BIT_POR])
      |=> !st_r.cause[RCR_BIT_POR];
   endproperty
   a_clr_por: assert property (p_clr_por)
      else $error("power-on cause not cleared");

   property p_clr_wdt;
      @(posedge clk) disable iff (!arst_n)
      (clr_bits[RCR_BIT_WDT] && !set_bits[RCR_BIT_WDT])
      |=> !st_r.cause[RCR_BIT_WDT];
   endproperty
   a_clr_wdt: assert property (p_clr_wdt)
      else $error("watchdog cause not cleared");

   property p_clr_swr;
      @(posedge clk) disable iff (!arst_n)
      (clr_bits[RCR_BIT_SWR] && !set_bits[RCR_BIT_SWR])
      |=> !st_r.cause[RCR_BIT_SWR];
   endproperty
   a_clr_swr: assert property (p_clr_swr)
      else $error("software cause not cleared");

   property p_clr_zero;
      @(posedge clk) disable iff (!arst_n)
      (clr_hit && clr_bits == 8'h00 && set_bits == 8'h00 && !ext_rise)
      |=> $stable(st_r.cause);
   endproperty
   a_clr_zero: assert property (p_clr_zero)
      else $error("zero clear changed the cause");

   property p_full_clr;
      @(posedge clk) disable iff (!arst_n)
      (clr_hit && (st_r.cause & ~clr_bits) == 8'h00 && !any_reset
       && st_r.pulse_cnt <= 4'h1) |=> !sys_rst_req;
   endproperty
   a_full_clr: assert property (p_full_clr)
      else $error("full clear raised a reset request");

   property p_reserved;
      @(posedge clk) disable iff (!arst_n)
      st_r.cause[7:3] == 5'h00;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved cause bit set");

   property p_remap_hold;
      @(posedge clk) disable iff (!arst_n)
      (!(wr_acc && apb_req.paddr == RCR_OFS_REMAP) && !any_reset)
      |=> $stable(sram_at_zero);
   endproperty
   a_remap_hold: assert property (p_remap_hold)
      else $error("remap changed without write or reset");

   // bus answer shape: one-cycle ready after every setup cycle
   property p_rdy_once;
      @(posedge clk) disable iff (!arst_n)
      apb_rsp.pready |=> !apb_rsp.pready;
   endproperty
   a_rdy_once: assert property (p_rdy_once)
      else $error("ready stood longer than one cycle");

   property p_rdy_answer;
      @(posedge clk) disable iff (!arst_n)
      (apb_req.psel && !apb_req.penable) |=> apb_rsp.pready;
   endproperty
   a_rdy_answer: assert property (p_rdy_answer)
      else $error("setup cycle not answered");

   property p_err_rdy;
      @(posedge clk) disable iff (!arst_n)
      apb_rsp.pslverr |-> apb_rsp.pready;
   endproperty
   a_err_rdy: assert property (p_err_rdy)
      else $error("error flag without ready");
endmodule : rcr_core

// ===== testbench/tb_reset_cause_and_remap.sv
/*
 testbench for rcr_core: apb register access, cause recording, reset
 request pulses and the low memory select.
 assumes the offsets and the two-cycle apb timing of rcr_pkg and notes.
*/
`timescale 1ns/1ps
module tb_reset_cause_and_remap;
   import rcr_pkg::*;
   logic         clk = 1'b0;
   logic         arst_n = 1'b0;
   rcr_apb_req_t apb_req = '0;
   rcr_apb_rsp_t apb_rsp;
   logic         por_evt = 1'b0;
   logic         wdt_evt = 1'b0;
   logic         ext_rst_evt = 1'b0;
   logic         sys_rst_req;
   logic         sram_at_zero;
   int           fail_count = 0;
   int           cmp_count = 0;
   logic [31:0]  rd;
   logic         er;

   always #2.5 clk = ~clk;

   rcr_core i_dut (.clk(clk), .arst_n(arst_n), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .por_evt(por_evt), .wdt_evt(wdt_evt),
      .ext_rst_evt(ext_rst_evt), .sys_rst_req(sys_rst_req),
      .sram_at_zero(sram_at_zero));

   ////////////////////////////////////////////////////////////////////////
   task complete_run;
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : complete_run

   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   // request held until the edge that samples pready high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         chk(1'b0, 1'b1, "pready timeout");
         complete_run();
      end
      rd = apb_rsp.prdata;
      er = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask : apb

   task rchk(input logic [11:0] a, input logic [31:0] e, input string m);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, e, m);
   endtask : rchk

   // request must appear, then stand exactly 8 cycles
   task pulse;
      int n;
      int h;
      n = 0;
      h = 0;
      while (sys_rst_req !== 1'b1 && n < 30) begin
         @(posedge clk);
         n++;
      end
      if (n >= 30) begin
         chk(1'b0, 1'b1, "no reset request");
         complete_run();
      end
      while (sys_rst_req === 1'b1 && h < 20) begin
         @(posedge clk);
         h++;
      end
      chk(h, 8, "reset request length");
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////
   task t_por;
      rchk(RCR_OFS_REMAP, 32'h0, "remap after reset");
      rchk(RCR_OFS_STATUS, 32'h0, "cause after reset");
      rchk(RCR_OFS_CLEAR, 32'h0, "clear reads zero");
      por_evt <= 1'b1;
      repeat (8) @(posedge clk);
      rchk(RCR_OFS_STATUS, 32'h1, "power-on cause");
      $display("t_por done");
   endtask : t_por

   task t_wdt;
      apb(1'b1, RCR_OFS_REMAP, 32'h1);
      @(posedge clk);
      chk(sram_at_zero, 1'b1, "sram at zero");
      rchk(RCR_OFS_REMAP, 32'h1, "remap readback");
      wdt_evt <= 1'b1;
      pulse();
      rchk(RCR_OFS_STATUS, 32'h3, "watchdog cause");
      chk(sram_at_zero, 1'b0, "flash back at zero");
      wdt_evt <= 1'b0;
      $display("t_wdt done");
   endtask : t_wdt

   task t_clear;
      int i;
      apb(1'b1, RCR_OFS_CLEAR, 32'h0);
      pulse();
      rchk(RCR_OFS_STATUS, 32'h3, "zero clear keeps bits");
      apb(1'b1, RCR_OFS_CLEAR, 32'h1);
      pulse();
      rchk(RCR_OFS_STATUS, 32'h2, "partial clear");
      apb(1'b1, RCR_OFS_CLEAR, 32'h2);
      for (i = 0; i < 12; i++) begin
         @(posedge clk);
         chk(sys_rst_req, 1'b0, "full clear no request");
      end
      rchk(RCR_OFS_STATUS, 32'h0, "all cleared");
      $display("t_clear done");
   endtask : t_clear

   task t_soft_ext;
      apb(1'b1, RCR_OFS_REMAP, 32'h1);
      apb(1'b1, RCR_OFS_STATUS, 32'h4);
      pulse();
      rchk(RCR_OFS_STATUS, 32'h4, "software cause");
      chk(sram_at_zero, 1'b0, "soft reset clears remap");
      apb(1'b1, RCR_OFS_REMAP, 32'h1);
      ext_rst_evt <= 1'b1;
      pulse();
      chk(sram_at_zero, 1'b0, "external clears remap");
      rchk(RCR_OFS_STATUS, 32'h0, "external gives null");
      ext_rst_evt <= 1'b0;
      apb(1'b1, 12'h00C, 32'h1);
      chk(er, 1'b1, "unmapped write error");
      apb(1'b0, 12'h00C, 32'h0);
      chk(er, 1'b1, "unmapped error");
      chk(rd, 32'h0, "unmapped data");
      $display("t_soft_ext done");
   endtask : t_soft_ext

   initial begin
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      t_por();
      t_wdt();
      t_clear();
      t_soft_ext();
      complete_run();
   end
endmodule : tb_reset_cause_and_remap
